// ==== pkg/rtc_sup_pkg.sv ====
`default_nettype none
package rtc_sup_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
  localparam int unsigned OSC_HZ           = 32768;
  localparam int unsigned RESET_HOLD_MS    = 140;
  localparam int unsigned RESET_HOLD_CYC   = RESET_HOLD_MS * CYC_PER_MS;
  localparam int unsigned DEBOUNCE_MS      = 20;
  localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_MS * CYC_PER_MS;
  localparam int unsigned WD_T0_MS         = 100;
  localparam int unsigned WD_T1_MS         = 200;
  localparam int unsigned WD_T2_MS         = 800;
  localparam int unsigned WD_T3_MS         = 1600;
  localparam int unsigned WD_T0_CYC        = WD_T0_MS * CYC_PER_MS;
  localparam int unsigned WD_T1_CYC        = WD_T1_MS * CYC_PER_MS;
  localparam int unsigned WD_T2_CYC        = WD_T2_MS * CYC_PER_MS;
  localparam int unsigned WD_T3_CYC        = WD_T3_MS * CYC_PER_MS;
  localparam int unsigned OSC_FAIL_PERIODS = 30;
  localparam int unsigned OSC_FAIL_CYC     = OSC_FAIL_PERIODS * CLK_HZ / OSC_HZ;

  // ********************************************************************
  // Oscillator divider taps
  // ********************************************************************
  localparam int unsigned PRESC_W     = 15;
  localparam int unsigned CADENCE_BIT = 14;
  localparam int unsigned TONE_1K_BIT = 4;
  localparam int unsigned TONE_2K_BIT = 3;
  localparam int unsigned TONE_4K_BIT = 2;
  localparam int unsigned TONE_8K_BIT = 1;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  CONFIG_OFS   = 8'h00;
  localparam logic [7:0]  STATUS_OFS   = 8'h04;
  localparam int unsigned CFG_W        = 7;
  localparam logic [6:0]  CONFIG_RST   = 7'h00;
  localparam int unsigned CFG_WD_EN    = 0;
  localparam int unsigned CFG_WD_SEL   = 1;
  localparam int unsigned CFG_TONE_SEL = 3;
  localparam int unsigned CFG_BUZZ_SRC = 5;
  localparam int unsigned CFG_BUZZ_ON  = 6;
  localparam int unsigned STS_OSC_FAIL = 0;
  localparam int unsigned STS_IN_RST   = 1;
  localparam int unsigned STS_BATT     = 2;
  localparam int unsigned STS_ALARM    = 3;
  localparam int unsigned STS_PINS     = 4;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_s;

  typedef struct packed {
    logic o;
    logic oe;
  } od_pin_s;

endpackage : rtc_sup_pkg
`default_nettype wire

// ==== logic/mr_debounce.sv ====
`default_nettype none
module mr_debounce
  import rtc_sup_pkg::*;
#(
  parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic raw_n,
  output logic      level_n
);

  logic        sample_q;
  logic [31:0] cnt_q;

  // A new level is taken only after it has stood for the whole window.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_q <= 1'b1;
      cnt_q    <= 32'h0;
      level_n  <= 1'b1;
    end else begin
      sample_q <= raw_n;
      if (sample_q == level_n) begin
        cnt_q <= 32'h0;
      end else if (cnt_q >= STABLE_CYC - 1) begin
        level_n <= sample_q;
        cnt_q   <= 32'h0;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  property p_db_stable;
    @(posedge aclk) disable iff (!aresetn)
      $changed(level_n) |-> $past(cnt_q) == STABLE_CYC - 1;
  endproperty
  a_db_stable: assert property (p_db_stable)
    else $error("Debounced level changed before the window ran out.");

endmodule : mr_debounce
`default_nettype wire

// ==== logic/osc_monitor.sv ====
`default_nettype none
module osc_monitor
  import rtc_sup_pkg::*;
#(
  parameter int unsigned FAIL_CYC = OSC_FAIL_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic osc_in,
  output logic      tick,
  output logic      fail
);

  logic        osc_q;
  logic        osc_qq;
  logic [31:0] gap_q;
  wire         rise = osc_q && !osc_qq;
  wire         gap_full = gap_q >= FAIL_CYC - 1;

  // The gap counter measures time since the last oscillator rising edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_q  <= 1'b0;
      osc_qq <= 1'b0;
      gap_q  <= 32'h0;
      tick   <= 1'b0;
      fail   <= 1'b0;
    end else begin
      osc_q  <= osc_in;
      osc_qq <= osc_q;
      tick   <= rise;
      if (rise) begin
        gap_q <= 32'h0;
        fail  <= 1'b0;
      end else if (gap_full) begin
        fail <= 1'b1;
      end else begin
        gap_q <= gap_q + 32'h1;
      end
    end
  end

  property p_osc_fail_set;
    @(posedge aclk) disable iff (!aresetn)
      (gap_full && !rise) |=> fail;
  endproperty
  a_osc_fail_set: assert property (p_osc_fail_set)
    else $error("Oscillator fail not raised after the missing-cycle window.");

  property p_osc_fail_clr;
    @(posedge aclk) disable iff (!aresetn)
      rise |=> !fail ##1 !fail;
  endproperty
  a_osc_fail_clr: assert property (p_osc_fail_clr)
    else $error("Oscillator fail stayed up although an edge arrived.");

endmodule : osc_monitor
`default_nettype wire

// ==== logic/rtc_supervisor.sv ====
// Contract
// - Battery flag output pulled low while running from the backup battery.
// - Resets held during low supply or manual reset, then for hold time.
// - Enabled watchdog without strobe in timeout asserts resets for hold time.
// - Watchdog timeout period comes from a configuration register field.
// - Manual reset is active low, pulled up, and debounced into one request.
// - Active-high reset output is always the complement of the active-low one.
// - Chip enable passes through only while no reset is active.
// - Power-fail output low in reset, else high while monitor input is above.
// - Buzzer tone is one of 1.024, 2.048, 4.096 or 8.192 kHz.
// - Buzzer turns on by alarm or by a configuration bit, as selected.
// - Active buzzer tone is gated by a 1 Hz cadence, half on half off.
// - Crystal fail raised after about thirty missed oscillator cycles.
// - Crystal fail is also readable as a status register bit.
// - Crystal fail output is open drain and active low.
// - Alarm output is open drain, active low, active on the alarm condition.
// - Timekeeping clock comes from the 32.768 kHz oscillator.
// - Registers are reached only through the serial register port; the code uses a parallel AXI-Lite slave port instead.
`default_nettype none
module rtc_supervisor
  import rtc_sup_pkg::*;
#(
  parameter int unsigned HOLD_CYC = RESET_HOLD_CYC,
  parameter int unsigned DEB_CYC  = DEBOUNCE_CYC,
  parameter int unsigned WD0_CYC  = WD_T0_CYC,
  parameter int unsigned WD1_CYC  = WD_T1_CYC,
  parameter int unsigned WD2_CYC  = WD_T2_CYC,
  parameter int unsigned WD3_CYC  = WD_T3_CYC,
  parameter int unsigned FAIL_CYC = OSC_FAIL_CYC
) (
  input  wire logic      aclk,
  input  wire logic      aresetn,
  input  wire axil_req_s axil_req,
  output var axil_rsp_s  axil_rsp,
  input  wire logic      vcc_low_in,
  input  wire logic      on_battery_in,
  input  wire logic      manual_reset_n,
  input  wire logic      watchdog_strobe_in,
  input  wire logic      supply_monitor_in,
  input  wire logic      ce_in_n,
  input  wire logic      osc_clk_in,
  input  wire logic      alarm_match_in,
  input  wire logic [3:0] od_pins_in,
  output var od_pin_s    reset_od,
  output var od_pin_s    battery_mode_flag_n,
  output var od_pin_s    osc_fail_out_n,
  output var od_pin_s    alarm_out_n,
  output logic           reset_out,
  output logic           ce_out_n,
  output logic           supply_fail_out_n,
  output logic           buzzer_drive
);

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [31:0] wd_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    wd_limit = WD0_CYC;
      2'h1:    wd_limit = WD1_CYC;
      2'h2:    wd_limit = WD2_CYC;
      default: wd_limit = WD3_CYC;
    endcase
  endfunction : wd_limit

  function automatic logic tone_pick(input logic [PRESC_W-1:0] div,
                                     input logic [1:0] sel);
    case (sel)
      2'h0:    tone_pick = div[TONE_1K_BIT];
      2'h1:    tone_pick = div[TONE_2K_BIT];
      2'h2:    tone_pick = div[TONE_4K_BIT];
      default: tone_pick = div[TONE_8K_BIT];
    endcase
  endfunction : tone_pick

  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic [CFG_W-1:0]   config_q;
  logic [31:0]        hold_q;
  logic [31:0]        wd_cnt_q;
  logic               in_reset_q;
  logic               strobe_q;
  logic [PRESC_W-1:0] div_q;
  logic               mr_level_n;
  logic               osc_tick;
  logic               osc_fail;

  // ********************************************************************
  // Submodules
  // ********************************************************************
  mr_debounce #(
    .STABLE_CYC (DEB_CYC)
  ) u_debounce (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw_n   (manual_reset_n),
    .level_n (mr_level_n)
  );

  osc_monitor #(
    .FAIL_CYC (FAIL_CYC)
  ) u_osc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .osc_in  (osc_clk_in),
    .tick    (osc_tick),
    .fail    (osc_fail)
  );

  // ********************************************************************
  // Reset generation and watchdog
  // ********************************************************************
  wire       wd_en      = config_q[CFG_WD_EN];
  wire [1:0] wd_sel     = config_q[CFG_WD_SEL +: 2];
  wire       strobe     = watchdog_strobe_in != strobe_q;
  wire       wd_fire    = wd_en && !in_reset_q && (wd_cnt_q >= wd_limit(wd_sel) - 1);
  wire       rst_cond   = vcc_low_in || !mr_level_n;
  wire       trig       = rst_cond || wd_fire;
  wire       in_reset_d = trig || (hold_q != 32'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q     <= HOLD_CYC;
      in_reset_q <= 1'b1;
    end else begin
      in_reset_q <= in_reset_d;
      if (trig) begin
        hold_q <= HOLD_CYC;
      end else if (hold_q != 32'h0) begin
        hold_q <= hold_q - 32'h1;
      end
    end
  end

  // Any transition on the strobe input restarts the timeout.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_q <= 1'b0;
      wd_cnt_q <= 32'h0;
    end else begin
      strobe_q <= watchdog_strobe_in;
      if (in_reset_q || !wd_en || strobe) begin
        wd_cnt_q <= 32'h0;
      end else begin
        wd_cnt_q <= wd_cnt_q + 32'h1;
      end
    end
  end

  // ********************************************************************
  // Buzzer
  // ********************************************************************
  wire buzz_src    = config_q[CFG_BUZZ_SRC];
  wire buzz_active = buzz_src ? alarm_match_in : config_q[CFG_BUZZ_ON];
  wire cadence_on  = div_q[CADENCE_BIT];
  wire tone        = tone_pick(div_q, config_q[CFG_TONE_SEL +: 2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
    end else if (osc_tick) begin
      div_q <= div_q + 1'b1;
    end
  end

  // ********************************************************************
  // Pin outputs
  // ********************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_od            <= '{o: 1'b0, oe: 1'b1};
      reset_out           <= 1'b1;
      ce_out_n            <= 1'b1;
      supply_fail_out_n   <= 1'b0;
      buzzer_drive        <= 1'b0;
      battery_mode_flag_n <= '{o: 1'b0, oe: 1'b0};
      osc_fail_out_n      <= '{o: 1'b0, oe: 1'b0};
      alarm_out_n         <= '{o: 1'b0, oe: 1'b0};
    end else begin
      reset_od            <= '{o: 1'b0, oe: in_reset_d};
      reset_out           <= in_reset_d;
      ce_out_n            <= in_reset_d | ce_in_n;
      supply_fail_out_n   <= !in_reset_d && supply_monitor_in;
      buzzer_drive        <= buzz_active && cadence_on && tone;
      battery_mode_flag_n <= '{o: 1'b0, oe: on_battery_in};
      osc_fail_out_n      <= '{o: 1'b0, oe: osc_fail};
      alarm_out_n         <= '{o: 1'b0, oe: alarm_match_in};
    end
  end

  // ********************************************************************
  // Register slave
  // ********************************************************************
  wire wr_start = axil_req.awvalid && axil_req.wvalid
                  && !axil_rsp.awready && !axil_rsp.bvalid;
  wire wr_fire  = axil_rsp.awready;
  wire wr_cfg   = axil_req.awaddr == CONFIG_OFS;
  wire wr_hit   = wr_cfg || axil_req.awaddr == STATUS_OFS;
  wire rd_start = axil_req.arvalid && !axil_rsp.arready && !axil_rsp.rvalid;
  wire rd_fire  = axil_rsp.arready;
  wire rd_cfg   = axil_req.araddr == CONFIG_OFS;
  wire rd_sts   = axil_req.araddr == STATUS_OFS;

  wire [31:0] status_word = {24'h0, od_pins_in, alarm_out_n.oe,
                             battery_mode_flag_n.oe, in_reset_q, osc_fail};
  wire [31:0] rd_word = rd_cfg ? {25'h0, config_q} :
                        rd_sts ? status_word : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      axil_rsp <= '0;
      config_q <= CONFIG_RST;
    end else begin
      axil_rsp.awready <= wr_start;
      axil_rsp.wready  <= wr_start;
      axil_rsp.arready <= rd_start;
      if (wr_fire) begin
        axil_rsp.bvalid <= 1'b1;
        axil_rsp.bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        if (wr_cfg && axil_req.wstrb[0]) begin
          config_q <= axil_req.wdata[CFG_W-1:0];
        end
      end else if (axil_req.bready) begin
        axil_rsp.bvalid <= 1'b0;
      end
      if (rd_fire) begin
        axil_rsp.rvalid <= 1'b1;
        axil_rsp.rdata  <= rd_word;
        axil_rsp.rresp  <= (rd_cfg || rd_sts) ? RESP_OKAY : RESP_SLVERR;
      end else if (axil_req.rready) begin
        axil_rsp.rvalid <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_release;
    (!trig && hold_q == 32'h1) ##1 !trig;
  endsequence

  property p_hold_load;
    rst_cond |=> in_reset_q && hold_q == HOLD_CYC;
  endproperty
  a_hold_load: assert property (p_hold_load)
    else $error("Reset not held with a full hold count.");

  property p_release;
    s_release |=> !in_reset_q && !reset_out && reset_od.oe == 1'b0;
  endproperty
  a_release: assert property (p_release)
    else $error("Reset not released when the hold time ran out.");

  property p_wd_fire;
    wd_fire |=> in_reset_q && hold_q == HOLD_CYC ##1 wd_cnt_q == 32'h0;
  endproperty
  a_wd_fire: assert property (p_wd_fire)
    else $error("Watchdog timeout did not start a reset.");

  property p_wd_limit;
    (wd_en && !in_reset_q && wd_cnt_q == wd_limit(wd_sel) - 1) |-> wd_fire;
  endproperty
  a_wd_limit: assert property (p_wd_limit)
    else $error("Watchdog did not fire at the selected timeout.");

  property p_complement;
    reset_out == reset_od.oe && reset_od.o == 1'b0;
  endproperty
  a_complement: assert property (p_complement)
    else $error("Reset outputs are not complementary.");

  property p_ce_block;
    in_reset_q |-> ce_out_n;
  endproperty
  a_ce_block: assert property (p_ce_block)
    else $error("Chip enable leaked through during reset.");

  property p_ce_pass;
    !in_reset_q |-> ce_out_n == $past(ce_in_n);
  endproperty
  a_ce_pass: assert property (p_ce_pass)
    else $error("Chip enable not passed through outside reset.");

  property p_pfo;
    in_reset_q |-> !supply_fail_out_n;
  endproperty
  a_pfo: assert property (p_pfo)
    else $error("Power-fail output high during reset.");

  property p_buzz_quiet;
    !cadence_on |=> !buzzer_drive;
  endproperty
  a_buzz_quiet: assert property (p_buzz_quiet)
    else $error("Buzzer sounded in the silent half of the cadence.");

  property p_flags;
    (on_battery_in |=> battery_mode_flag_n.oe) and (osc_fail |=> osc_fail_out_n.oe);
  endproperty
  a_flags: assert property (p_flags)
    else $error("Battery or oscillator flag not pulled low.");

  property p_alarm;
    alarm_match_in |=> alarm_out_n.oe && !alarm_out_n.o;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("Alarm output not pulled low on alarm.");

endmodule : rtc_supervisor
`default_nettype wire

// ==== testbench/host_ram_model.sv ====
`default_nettype none
module host_ram_model (
  input  wire logic aclk,
  input  wire logic strobe_en,
  input  wire logic ce_req_n,
  output logic      ce_in_n,
  output logic      watchdog_strobe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] gap_q;
  initial begin
    gap_q = 5'h00;
    ce_in_n = 1'b1;
    watchdog_strobe_in = 1'b0;
  end
  // The host strobes well inside the shortest timeout while it is alive.
  always @(posedge aclk) begin
    gap_q <= gap_q + 5'h01;
    ce_in_n <= ce_req_n;
    if (strobe_en && gap_q == 5'h1f) watchdog_strobe_in <= !watchdog_strobe_in;
  end
endmodule : host_ram_model
`default_nettype wire

// ==== testbench/testbench.sv ====
`default_nettype none
module testbench
  import rtc_sup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn, vcc_low, on_batt, mr_n, sup_mon, alarm_m, ce_req_n, osc_en;
  logic        reset_out, ce_out_n, sfo_n, buzz, strobe_en;
  logic [1:0]  ph_q = 2'h0;
  logic [31:0] d;
  int          n, bad_count, check_count;
  logic [33:0] exp_q[$];
  axil_req_s   req;
  axil_rsp_s   rsp;
  od_pin_s     rst_od, batt_od, osc_od, alm_od;
  wire logic   ce_in_n, wds;
  wire logic [3:0] pins_w = ~{alm_od.oe, osc_od.oe, batt_od.oe, rst_od.oe};
  wire logic   osc = ph_q[0];

  always #12.5 aclk = ~aclk;
  always @(posedge aclk) if (osc_en) ph_q <= ph_q + 2'h1;

  host_ram_model u_host (.aclk(aclk), .strobe_en(strobe_en), .ce_req_n(ce_req_n),
    .ce_in_n(ce_in_n), .watchdog_strobe_in(wds));

  rtc_supervisor #(.HOLD_CYC(20), .DEB_CYC(8), .WD0_CYC(50), .WD1_CYC(100),
    .WD2_CYC(200), .WD3_CYC(400), .FAIL_CYC(40)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
    .vcc_low_in(vcc_low), .on_battery_in(on_batt), .manual_reset_n(mr_n),
    .watchdog_strobe_in(wds), .supply_monitor_in(sup_mon), .ce_in_n(ce_in_n),
    .osc_clk_in(osc), .alarm_match_in(alarm_m), .od_pins_in(pins_w),
    .reset_od(rst_od), .battery_mode_flag_n(batt_od), .osc_fail_out_n(osc_od),
    .alarm_out_n(alm_od), .reset_out(reset_out), .ce_out_n(ce_out_n),
    .supply_fail_out_n(sfo_n), .buzzer_drive(buzz));

  // ****************************************************************
  // Compare and report
  // ****************************************************************
  task automatic cmp_word(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_pin(input logic got, input logic exp);
    cmp_word({33'h0, got}, {33'h0, exp});
  endtask : cmp_pin

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  always @(posedge aclk) begin
    if (rsp.bvalid && req.bready) cmp_word({rsp.bresp, 32'h0}, exp_q.pop_front());
    if (rsp.rvalid && req.rready) cmp_word({rsp.rresp, rsp.rdata}, exp_q.pop_front());
  end

  // ****************************************************************
  // Bus and timing helpers
  // ****************************************************************
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    int k;
    @(posedge aclk);
    exp_q.push_back({r, 32'h0});
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      k++;
    end while (!rsp.bvalid && k < 50);
    if (!rsp.bvalid) bad_count++;
    req.bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    int k;
    @(posedge aclk);
    exp_q.push_back(e);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
      k++;
    end while (!rsp.rvalid && k < 50);
    if (!rsp.rvalid) bad_count++;
    req.rready <= 1'b0;
  endtask : axi_rd

  task automatic wait_rise(input int lim, output int c);
    logic p;
    c = 0;
    do begin
      p = buzz;
      @(posedge aclk);
      c++;
    end while (!(buzz && !p) && c <= lim);
  endtask : wait_rise

  task automatic test_end(input string s);
    $display("test %s done", s);
  endtask : test_end

  initial begin
    #(25 * 105000);
    bad_count++;
    final_report();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    bad_count = 0;
    check_count = 0;
    req = '0;
    strobe_en = 1'b1;
    {vcc_low, on_batt, alarm_m, ce_req_n} = 4'h0;
    {mr_n, sup_mon, osc_en} = 3'h7;
    aresetn = 1'b0;
    void'($urandom(3145));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    cmp_pin(reset_out, 1'b1);
    cmp_pin(rst_od.oe, 1'b1);
    cmp_pin(ce_out_n, 1'b1);
    cmp_pin(sfo_n, 1'b0);
    sup_mon <= 1'b0;
    ce_req_n <= 1'b1;
    repeat (3) @(posedge aclk);
    cmp_pin(ce_out_n, 1'b1);
    test_end("reset pins");
    on_batt <= 1'b1;
    alarm_m <= 1'b1;
    repeat (3) @(posedge aclk);
    cmp_pin(batt_od.oe, 1'b1);
    cmp_pin(alm_od.oe, 1'b1);
    on_batt <= 1'b0;
    alarm_m <= 1'b0;
    repeat (3) @(posedge aclk);
    cmp_pin(batt_od.oe, 1'b0);
    cmp_pin(alm_od.oe, 1'b0);
    test_end("flags");
    d = $urandom;
    axi_wr(CONFIG_OFS, d, RESP_OKAY);
    axi_rd(CONFIG_OFS, {RESP_OKAY, 25'h0, d[6:0]});
    axi_wr(8'h08, d, RESP_SLVERR);
    axi_rd(8'h08, {RESP_SLVERR, 32'h0});
    test_end("registers");
    osc_en <= 1'b0;
    repeat (50) @(posedge aclk);
    cmp_pin(osc_od.oe, 1'b1);
    cmp_pin(osc_od.o, 1'b0);
    axi_rd(STATUS_OFS, {RESP_OKAY, 32'h000000b1});
    osc_en <= 1'b1;
    repeat (12) @(posedge aclk);
    cmp_pin(osc_od.oe, 1'b0);
    test_end("oscillator fail");
    sup_mon <= 1'b1;
    ce_req_n <= 1'b0;
    repeat (3) @(posedge aclk);
    cmp_pin(reset_out, 1'b0);
    cmp_pin(ce_out_n, 1'b0);
    cmp_pin(sfo_n, 1'b1);
    vcc_low <= 1'b1;
    repeat (2) @(posedge aclk);
    cmp_pin(reset_out, 1'b1);
    cmp_pin(ce_out_n, 1'b1);
    cmp_pin(sfo_n, 1'b0);
    vcc_low <= 1'b0;
    repeat (20) @(posedge aclk);
    cmp_pin(reset_out, 1'b1);
    repeat (3) @(posedge aclk);
    cmp_pin(reset_out, 1'b0);
    mr_n <= 1'b0;
    repeat (4) @(posedge aclk);
    mr_n <= 1'b1;
    repeat (12) @(posedge aclk);
    cmp_pin(reset_out, 1'b0);
    mr_n <= 1'b0;
    repeat (12) @(posedge aclk);
    cmp_pin(reset_out, 1'b1);
    mr_n <= 1'b1;
    repeat (28) @(posedge aclk);
    cmp_pin(reset_out, 1'b1);
    repeat (4) @(posedge aclk);
    cmp_pin(reset_out, 1'b0);
    test_end("supervisor");
    for (int s = 0; s < 2; s++) begin
      axi_wr(CONFIG_OFS, 32'h01 | (s << 1), RESP_OKAY);
      @(wds);
      @(posedge aclk);
      strobe_en <= 1'b0;
      repeat ((50 << s) - 5) @(posedge aclk);
      cmp_pin(reset_out, 1'b0);
      repeat (10) @(posedge aclk);
      cmp_pin(reset_out, 1'b1);
      strobe_en <= 1'b1;
      repeat (30) @(posedge aclk);
    end
    test_end("watchdog");
    for (int s = 0; s < 4; s++) begin
      axi_wr(CONFIG_OFS, 32'h40 | (s << 3), RESP_OKAY);
      wait_rise(40000, n);
      wait_rise(300, n);
      wait_rise(300, n);
      cmp_word(34'(n), 34'(4 << (TONE_1K_BIT - s)));
    end
    axi_wr(CONFIG_OFS, 32'h00, RESP_OKAY);
    wait_rise(300, n);
    cmp_pin(n > 300, 1'b1);
    alarm_m <= 1'b1;
    axi_wr(CONFIG_OFS, 32'h38, RESP_OKAY);
    wait_rise(300, n);
    cmp_pin(n <= 300, 1'b1);
    for (int k = 0; k < 5000 && n <= 100; k++) wait_rise(100, n);
    wait_rise(40000, n);
    cmp_pin(n > 32600 && n <= 32800, 1'b1);
    test_end("buzzer");
    final_report();
  end
endmodule : testbench
`default_nettype wire
